// *** rtl/crc_engine.sv ***
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module crc_engine
    import crc_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [DATA_W-1:0] wb_dat_i,
    output logic      [DATA_W-1:0] wb_dat_o,
    output logic                   wb_ack_o
);
    logic [MODE_W-1:0]  mode;
    logic [DATA_W-1:0]  seed;
    logic [DATA_W-1:0]  acc;
    logic [DATA_W-1:0]  word;
    logic [LEN_W-1:0]   left;
    eng_e               state;
    logic               ack;
    poly_e              poly;
    logic               wide;
    logic [DATA_W-1:0]  mask;
    logic               req;
    logic               go;
    logic               wr;
    logic               busy;
    logic               hit_mode;
    logic               hit_seed;
    logic               hit_sum;
    logic               hit_data;
    logic               hit_status;
    logic [LEN_W-1:0]   nbytes;
    logic [DATA_W-1:0]  next_seed;
    logic [DATA_W-1:0]  next_acc;
    logic [DATA_W-1:0]  sum_view;
    logic [7:0]         raw_byte;
    logic [7:0]         in_byte;
    logic               step;
    logic               take;
    logic [LEN_W-1:0]   take_len;
    logic               fifo_in_valid;
    logic               fifo_in_ready;
    logic [ENTRY_W-1:0] fifo_in_data;
    logic               fifo_out_valid;
    logic               fifo_out_ready;
    logic [ENTRY_W-1:0] fifo_out_data;
    logic               fifo_empty;
    logic               fifo_full;

    function automatic logic [7:0] rev8(input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            rev8[i] = d[7-i];
        end
    endfunction

    function automatic logic [DATA_W-1:0] rev_w(input logic [DATA_W-1:0] d,
                                                input logic w);
        rev_w = '0;
        for (int i = 0; i < DATA_W; i++) begin
            if (w) begin
                rev_w[i] = d[DATA_W-1-i];
            end else if (i < HALF_W) begin
                rev_w[i] = d[HALF_W-1-i];
            end
        end
    endfunction

    // only contiguous, naturally aligned lane groups count as data
    function automatic logic [LEN_W-1:0] lane_count(input logic [3:0] s);
        case (s)
            4'h1, 4'h2, 4'h4, 4'h8: lane_count = BYTES_8;
            4'h3, 4'hC:             lane_count = BYTES_16;
            4'hF:                   lane_count = BYTES_32;
            default:                lane_count = BYTES_NONE;
        endcase
    endfunction

    function automatic logic [DATA_W-1:0] lane_align(input logic [3:0] s,
                                                     input logic [DATA_W-1:0] d);
        case (s)
            4'h2:       lane_align = {8'h00, d[31:8]};
            4'h4, 4'hC: lane_align = {16'h0000, d[31:16]};
            4'h8:       lane_align = {24'h00_0000, d[31:24]};
            default:    lane_align = d;
        endcase
    endfunction

    // reserved poly code 3 falls back to the 32-bit polynomial
    assign poly = (mode[MODE_POLY+:2] == 2'h3) ? POLY_CRC32
                                                : poly_e'(mode[MODE_POLY+:2]);
    assign wide = (poly == POLY_CRC32);
    assign mask = wide ? MASK32 : MASK16;

    // ---------------- wishbone slave ----------------
    assign hit_mode   = (wb_adr_i == OFF_MODE);
    assign hit_seed   = (wb_adr_i == OFF_SEED);
    assign hit_sum    = (wb_adr_i == OFF_SUM);
    assign hit_data   = (wb_adr_i == OFF_DATA);
    assign hit_status = (wb_adr_i == OFF_STATUS);
    assign nbytes     = lane_count(wb_sel_i);
    assign busy       = (state == ENG_RUN) || !fifo_empty;
    assign req        = wb_cyc_i && wb_stb_i && !ack;
    assign wb_ack_o   = ack && ce;
    assign wr         = wb_ack_o && wb_we_i;

    // mode and seed writes and sum reads wait for the pipe to drain so they stay coherent
    always_comb begin
        go = 1'b1;
        if (hit_data && wb_we_i && nbytes != BYTES_NONE) begin
            go = fifo_in_ready;
        end
        if ((hit_mode || hit_seed) && wb_we_i) begin
            go = !busy;
        end
        if (hit_sum && !wb_we_i) begin
            go = !busy;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ack <= 1'b0;
        end else if (ce) begin
            ack <= req && go;
        end
    end

    always_comb begin
        next_seed = seed;
        for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) begin
                next_seed[b*8+:8] = wb_dat_i[b*8+:8];
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mode <= MODE_RESET;
        end else if (wr && hit_mode && wb_sel_i[0]) begin
            mode <= wb_dat_i[MODE_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            seed <= SEED_RESET;
        end else if (wr && hit_seed) begin
            seed <= next_seed;
        end
    end

    always_comb begin
        sum_view = acc & mask;
        if (mode[MODE_SUM_REV]) begin
            sum_view = rev_w(acc, wide);
        end
        if (mode[MODE_SUM_CMP]) begin
            sum_view = ~sum_view & mask;
        end
    end

    // read data is latched with the ack; unmapped and write-only read zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wb_dat_o <= '0;
        end else if (ce && req && go && !wb_we_i) begin
            wb_dat_o <= '0;
            if (hit_mode) begin
                wb_dat_o <= {{(DATA_W-MODE_W){1'b0}}, mode};
            end
            if (hit_seed) begin
                wb_dat_o <= seed;
            end
            if (hit_sum) begin
                wb_dat_o <= sum_view;
            end
            if (hit_status) begin
                wb_dat_o[ST_BUSY] <= busy;
                wb_dat_o[ST_FULL] <= fifo_full;
            end
        end
    end

    // ---------------- data path ----------------
    assign fifo_in_valid = wr && hit_data && nbytes != BYTES_NONE;
    assign fifo_in_data  = {nbytes, lane_align(wb_sel_i, wb_dat_i)};

    crc_fifo #(
        .WIDTH (ENTRY_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .ce        (ce),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data),
        .empty     (fifo_empty),
        .full      (fifo_full)
    );

    // the first byte is worked in the same cycle the entry is taken
    assign fifo_out_ready = (state == ENG_IDLE);
    assign take     = fifo_out_valid && (state == ENG_IDLE);
    assign take_len = fifo_out_data[ENTRY_W-1:DATA_W];
    assign step     = take || (state == ENG_RUN);
    assign raw_byte = (state == ENG_RUN) ? word[7:0] : fifo_out_data[7:0];

    always_comb begin
        in_byte = raw_byte;
        if (mode[MODE_IN_REV]) begin
            in_byte = rev8(in_byte);
        end
        if (mode[MODE_IN_CMP]) begin
            in_byte = ~in_byte;
        end
    end

    crc_step u_step (
        .poly    (poly),
        .acc_in  (acc),
        .byte_in (in_byte),
        .acc_out (next_acc)
    );

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= ENG_IDLE;
            word  <= '0;
            left  <= '0;
        end else if (ce) begin
            case (state)
                ENG_IDLE: begin
                    if (take) begin
                        word <= {8'h00, fifo_out_data[DATA_W-1:8]};
                        left <= take_len - 1'b1;
                        if (take_len > BYTES_8) begin
                            state <= ENG_RUN;
                        end
                    end
                end
                ENG_RUN: begin
                    word <= {8'h00, word[DATA_W-1:8]};
                    left <= left - 1'b1;
                    if (left == BYTES_8) begin
                        state <= ENG_IDLE;
                    end
                end
                default: state <= ENG_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            acc <= SEED_RESET;
        end else if (wr && hit_seed) begin
            acc <= next_seed & mask;
        end else if (ce && step) begin
            acc <= next_acc;
        end
    end

    // ---------------- checks ----------------
    a_ack_single_cycle: assert property (
        @(posedge clk_sys) disable iff (rst || !ce)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack stood longer than one cycle");

    a_no_push_full: assert property (
        @(posedge clk_sys) disable iff (rst || !ce)
        fifo_in_valid |-> fifo_in_ready && !fifo_full)
        else $error("data entered a full buffer");

    a_ccitt_step: assert property (
        @(posedge clk_sys) disable iff (rst || !ce)
        step && acc == '0 && in_byte == 8'h01 && poly == POLY_CCITT
        |=> acc == GEN_CCITT)
        else $error("ccitt step gave wrong remainder");

    a_crc16_step: assert property (
        @(posedge clk_sys) disable iff (rst || !ce)
        step && acc == '0 && in_byte == 8'h01 && poly == POLY_CRC16
        |=> acc == GEN_CRC16)
        else $error("crc16 step gave wrong remainder");

    a_crc32_step: assert property (
        @(posedge clk_sys) disable iff (rst || !ce)
        step && acc == '0 && in_byte == 8'h01 && poly == POLY_CRC32
        |=> acc == GEN_CRC32)
        else $error("crc32 step gave wrong remainder");

    a_one_byte_write: assert property (
        @(posedge clk_sys) disable iff (rst || !ce)
        take && take_len == BYTES_8 |=> state == ENG_IDLE)
        else $error("byte write took more than one cycle");

    a_two_byte_write: assert property (
        @(posedge clk_sys) disable iff (rst || !ce)
        take && take_len == BYTES_16
        |=> state == ENG_RUN ##1 state == ENG_IDLE)
        else $error("halfword write not two cycles");

    a_four_byte_write: assert property (
        @(posedge clk_sys) disable iff (rst || !ce)
        take && take_len == BYTES_32
        |=> (state == ENG_RUN)[*3] ##1 state == ENG_IDLE)
        else $error("word write not four cycles");

    a_low_byte_first: assert property (
        @(posedge clk_sys) disable iff (rst || !ce)
        take && take_len > BYTES_8
        |=> raw_byte == $past(fifo_out_data[15:8]))
        else $error("second byte not next ascending byte");

    a_width_sets_len: assert property (
        @(posedge clk_sys) disable iff (rst || !ce)
        fifo_in_valid && wb_sel_i == 4'hF
        |-> fifo_in_data[ENTRY_W-1:DATA_W] == BYTES_32)
        else $error("full word write not counted as four bytes");

    a_seed_loads: assert property (
        @(posedge clk_sys) disable iff (rst || !ce)
        wr && hit_seed |=> acc == ($past(next_seed) & $past(mask)))
        else $error("seed write did not load accumulator");

    a_in_complement: assert property (
        @(posedge clk_sys) disable iff (rst || !ce)
        step && mode[MODE_IN_CMP] && !mode[MODE_IN_REV]
        |-> in_byte == ~raw_byte)
        else $error("input complement not applied");

    a_sum_complement: assert property (
        @(posedge clk_sys) disable iff (rst || !ce)
        wb_ack_o && hit_sum && !wb_we_i && wide
        && mode[MODE_SUM_CMP] && !mode[MODE_SUM_REV]
        |-> wb_dat_o == ~acc)
        else $error("sum complement not applied");

    a_sum_high_zero: assert property (
        @(posedge clk_sys) disable iff (rst || !ce)
        wb_ack_o && hit_sum && !wb_we_i && !wide
        |-> wb_dat_o[DATA_W-1:HALF_W] == '0)
        else $error("16-bit sum has upper bits set");
endmodule
`default_nettype wire

// *** rtl/crc_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module crc_fifo #(
    parameter int WIDTH = 35,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  empty,
    output logic                  full
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    logic             push;
    logic             load;

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign full     = (count == CNT_W'(DEPTH));
    assign in_ready = !full;
    assign empty    = (count == '0) && !out_valid;
    assign push     = ce && in_valid && in_ready;
    // output register refills whenever it empties or is consumed and memory holds an entry
    assign load     = ce && (count != '0) && (!out_valid || out_ready);

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= ptr_inc(wr_ptr);
            end
            if (load) begin
                rd_ptr <= ptr_inc(rd_ptr);
            end
            count <= count + CNT_W'(push) - CNT_W'(load);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (load) begin
            out_valid <= 1'b1;
            out_data  <= mem[rd_ptr];
        end else if (ce && out_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** rtl/crc_pkg.sv ***
`default_nettype none
package crc_pkg;
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 32;
    localparam int          HALF_W       = 16;
    localparam int          LEN_W        = 3;
    localparam int          ENTRY_W      = LEN_W + DATA_W;
    localparam int          FIFO_DEPTH   = 16;

    // register offsets, byte addresses
    localparam logic [ADDR_W-1:0] OFF_MODE   = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_SEED   = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_SUM    = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_DATA   = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;

    // mode register fields
    localparam int          MODE_W       = 6;
    localparam int          MODE_POLY    = 0;
    localparam int          MODE_IN_REV  = 2;
    localparam int          MODE_IN_CMP  = 3;
    localparam int          MODE_SUM_REV = 4;
    localparam int          MODE_SUM_CMP = 5;
    localparam logic [MODE_W-1:0] MODE_RESET = 6'h00;
    localparam logic [DATA_W-1:0] SEED_RESET = 32'hFFFF_FFFF;

    // status register fields
    localparam int          ST_BUSY      = 0;
    localparam int          ST_FULL      = 1;

    // bytes per data write
    localparam logic [LEN_W-1:0] BYTES_NONE = 3'h0;
    localparam logic [LEN_W-1:0] BYTES_8    = 3'h1;
    localparam logic [LEN_W-1:0] BYTES_16   = 3'h2;
    localparam logic [LEN_W-1:0] BYTES_32   = 3'h4;

    // generator polynomials, top term implied
    localparam logic [DATA_W-1:0] GEN_CCITT = 32'h0000_1021;
    localparam logic [DATA_W-1:0] GEN_CRC16 = 32'h0000_8005;
    localparam logic [DATA_W-1:0] GEN_CRC32 = 32'h04C1_1DB7;
    localparam logic [DATA_W-1:0] MASK16    = 32'h0000_FFFF;
    localparam logic [DATA_W-1:0] MASK32    = 32'hFFFF_FFFF;

    typedef enum logic [1:0] {
        POLY_CCITT = 2'h0,
        POLY_CRC16 = 2'h1,
        POLY_CRC32 = 2'h2
    } poly_e;

    typedef enum logic {
        ENG_IDLE = 1'b0,
        ENG_RUN  = 1'b1
    } eng_e;
endpackage
`default_nettype wire

// *** rtl/crc_step.sv ***
`timescale 1ns/1ps
`default_nettype none
module crc_step
    import crc_pkg::*;
(
    input  wire poly_e             poly,
    input  wire logic [DATA_W-1:0] acc_in,
    input  wire logic [7:0]        byte_in,
    output logic      [DATA_W-1:0] acc_out
);
    logic [DATA_W-1:0] gen;
    logic [DATA_W-1:0] c;
    logic              fb;

    assign gen = (poly == POLY_CRC32) ? GEN_CRC32 :
                 (poly == POLY_CRC16) ? GEN_CRC16 : GEN_CCITT;

    // one byte per call, msb of the byte enters first
    always_comb begin
        c  = acc_in;
        fb = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            if (poly == POLY_CRC32) begin
                fb = c[DATA_W-1] ^ byte_in[i];
                c  = {c[DATA_W-2:0], 1'b0} ^ (fb ? gen : '0);
            end else begin
                fb = c[HALF_W-1] ^ byte_in[i];
                c  = {16'h0000, c[HALF_W-2:0], 1'b0} ^ (fb ? gen : '0);
            end
        end
        acc_out = c;
    end
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench
    import crc_pkg::*;
;
    logic              clk_sys;
    logic              rst;
    logic              cyc;
    logic              stb;
    logic              we;
    logic [ADDR_W-1:0] adr;
    logic [3:0]        sel;
    logic [DATA_W-1:0] wdat;
    logic [DATA_W-1:0] rdat;
    logic              ack;
    logic [DATA_W-1:0] acc;
    logic [MODE_W-1:0] mode;
    int                miscompares;
    int                total_checks;

    initial clk_sys = 1'b0;
    always #25 clk_sys = ~clk_sys;

    crc_engine #(.DEPTH(FIFO_DEPTH)) dut (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .ce       (1'b1),
        .wb_cyc_i (cyc),
        .wb_stb_i (stb),
        .wb_we_i  (we),
        .wb_adr_i (adr),
        .wb_sel_i (sel),
        .wb_dat_i (wdat),
        .wb_dat_o (rdat),
        .wb_ack_o (ack)
    );

    wb_master m (
        .clk_sys (clk_sys),
        .ack     (ack),
        .rdat    (rdat),
        .cyc     (cyc),
        .stb     (stb),
        .we      (we),
        .adr     (adr),
        .sel     (sel),
        .wdat    (wdat)
    );

    // reference: non-reflected shift, bits of each byte msb first
    function automatic logic [31:0] step(input logic [31:0] a,
                                         input logic [7:0] b);
        logic [31:0] g;
        logic [7:0]  x;
        logic        fb;
        int          w;
        g = (mode[1:0] == 2'h0) ? GEN_CCITT :
            (mode[1:0] == 2'h1) ? GEN_CRC16 : GEN_CRC32;
        w = mode[1] ? 32 : 16;
        for (int i = 0; i < 8; i++) x[i] = mode[MODE_IN_REV] ? b[7-i] : b[i];
        if (mode[MODE_IN_CMP]) x = ~x;
        for (int i = 7; i >= 0; i--) begin
            fb = a[w-1] ^ x[i];
            a = a << 1;
            if (fb) a = a ^ g;
        end
        return (w == 16) ? (a & MASK16) : a;
    endfunction

    function automatic logic [31:0] sum_exp();
        logic [31:0] s;
        logic [31:0] r;
        logic [31:0] k;
        int          w;
        w = mode[1] ? 32 : 16;
        k = mode[1] ? MASK32 : MASK16;
        s = acc & k;
        r = '0;
        for (int i = 0; i < w; i++) r[i] = s[w-1-i];
        if (mode[MODE_SUM_REV]) s = r;
        if (mode[MODE_SUM_CMP]) s = ~s & k;
        return s;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d);
        logic [31:0] q;
        m.xfer(1'b1, a, s, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        m.xfer(1'b0, a, 4'hF, 32'h0, q);
        chk(q, e);
    endtask

    // lanes enter lowest first
    task automatic feed(input logic [3:0] s, input logic [31:0] d);
        wr(OFF_DATA, s, d);
        for (int l = 0; l < 4; l++) if (s[l]) acc = step(acc, d[8*l +: 8]);
    endtask

    task automatic set_mode(input logic [5:0] v);
        mode = v;
        wr(OFF_MODE, 4'h1, {26'h0, v});
        rd(OFF_MODE, {26'h0, v});
    endtask

    task automatic load_seed(input logic [31:0] v);
        wr(OFF_SEED, 4'hF, v);
        acc = v & (mode[1] ? MASK32 : MASK16);
        rd(OFF_SEED, v);
    endtask

    // nine ascii digits; fixed check values guard the reference too
    task automatic known(input logic [5:0] v, input logic [31:0] sd,
                         input logic [31:0] e);
        set_mode(v);
        load_seed(sd);
        feed(4'hF, 32'h3433_3231);
        feed(4'hF, 32'h3837_3635);
        feed(4'h1, 32'h0000_0039);
        rd(OFF_SUM, e);
    endtask

    // lone 0x01 byte from a zero seed leaves the generator itself
    task automatic gen_one(input logic [5:0] v, input logic [31:0] e);
        set_mode(v);
        load_seed(32'h0);
        feed(4'h1, 32'h0000_0001);
        rd(OFF_SUM, e);
    endtask

    task automatic end_sim();
        if (miscompares == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk_sys);
        miscompares++;
        end_sim();
    end

    initial begin
        rst = 1'b1;
        miscompares = 0;
        total_checks = 0;
        mode = MODE_RESET;
        acc = SEED_RESET & MASK16;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd(OFF_MODE, {26'h0, MODE_RESET});
        rd(OFF_SEED, SEED_RESET);
        rd(OFF_SUM, sum_exp());
        wr(8'h20, 4'hF, 32'hDEAD_BEEF);
        rd(8'h20, 32'h0);
        rd(OFF_DATA, 32'h0);
        known(6'h00, 32'hFFFF_FFFF, 32'h0000_29B1);
        known(6'h01, 32'h0000_0000, 32'h0000_FEE8);
        known(6'h02, 32'hFFFF_FFFF, 32'h0376_E6E7);
        known(6'h03, 32'hFFFF_FFFF, 32'h0376_E6E7);
        gen_one(6'h00, GEN_CCITT);
        gen_one(6'h01, GEN_CRC16);
        gen_one(6'h02, GEN_CRC32);
        for (int p = 0; p < 3; p++) begin
            for (int o = 0; o < 16; o++) begin
                set_mode(6'(o * 4 + p));
                load_seed(32'hA5C3_0F96 ^ 32'(o * 977 + p));
                feed(4'hF, 32'h3A7E_91C4 ^ 32'(o));
                feed(4'h3, 32'h5B20_C817);
                feed(4'hC, 32'hE4D1_6F08);
                feed(4'h2, 32'h0077_8800);
                feed(4'h8, 32'h9100_0000);
                // odd lane pattern is dropped, sum must not move
                wr(OFF_DATA, 4'h5, 32'hFFFF_FFFF);
                rd(OFF_SUM, sum_exp());
            end
        end
        // stream faster than bytes drain: buffer fills and stalls the bus
        set_mode(6'h02);
        load_seed(32'hFFFF_FFFF);
        // writes every 3 cycles, drain every 4: backlog passes the depth
        for (int i = 0; i < 80; i++) feed(4'hF, 32'h0102_0304 * i);
        rd(OFF_STATUS, (32'h1 << ST_BUSY) | (32'h1 << ST_FULL));
        rd(OFF_SUM, sum_exp());
        rd(OFF_STATUS, 32'h0);
        end_sim();
    end
endmodule
`default_nettype wire

// *** verif/wb_master.sv ***
`timescale 1ns/1ps
`default_nettype none
module wb_master
    import crc_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              ack,
    input  wire logic [DATA_W-1:0] rdat,
    output logic                   cyc,
    output logic                   stb,
    output logic                   we,
    output logic      [ADDR_W-1:0] adr,
    output logic      [3:0]        sel,
    output logic      [DATA_W-1:0] wdat
);
    initial begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = '0;
        sel = '0;
        wdat = '0;
    end

    // entered just after a rising edge; leaves one idle cycle behind
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                        input logic [3:0] s, input logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        @(posedge clk_sys);
        while (ack !== 1'b1) @(posedge clk_sys);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        // released lines must not keep showing the old value
        adr <= ~a;
        sel <= ~s;
        wdat <= ~d;
        @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire
